// ---- verilog/sgdrd_top.sv ----
// two-channel scatter-gather mover: register window, descriptor walk, data moves
`default_nettype none
module sgdrd_top (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic             host_rd_valid_out,
    output logic      [31:0] host_rd_addr_out,
    input  wire logic        host_rd_ready_in,
    input  wire logic        host_rdata_valid_in,
    input  wire logic [31:0] host_rdata_in,
    output logic             host_wr_valid_out,
    output logic      [31:0] host_wr_addr_out,
    output logic      [31:0] host_wr_data_out,
    input  wire logic        host_wr_ready_in,
    output logic             ddr_rd_valid_out,
    output logic      [23:0] ddr_rd_addr_out,
    input  wire logic        ddr_rd_ready_in,
    input  wire logic        ddr_rdata_valid_in,
    input  wire logic [31:0] ddr_rdata_in,
    output logic             ddr_wr_valid_out,
    output logic      [23:0] ddr_wr_addr_out,
    output logic      [31:0] ddr_wr_data_out,
    input  wire logic        ddr_wr_ready_in,
    input  wire logic [31:0] dip_in,
    output logic      [31:0] lamp_out,
    output logic      [1:0]  chan_done_out
);
    typedef struct packed {
        logic [31:0]                 scratch;
        logic [31:0]                 ctrl;
        logic [1:0][31:0]            ptr;
        logic [31:0]                 lamp;
        logic [1:0][31:0]            clks;
        logic [1:0][7:0]             err;
        logic [1:0][23:0]            bytes;
        logic [1:0]                  pend;
        logic                        chan;
        sgdrd_pkg::sgdrd_state_t     st;
        logic [31:0]                 desc_ptr;
        logic [1:0]                  fidx;
        logic [31:0]                 w_host;
        logic [31:0]                 w_ctl;
        logic [31:0]                 w_offs;
        logic [31:0]                 src;
        logic [23:0]                 ddr;
        logic [20:0]                 left;
        logic                        hrd_v;
        logic [31:0]                 hrd_a;
        logic                        drd_v;
        logic [23:0]                 drd_a;
        logic [31:0]                 rdata;
        logic                        rvalid;
        logic [1:0]                  done;
    } sgdrd_top_state_t;

    sgdrd_top_state_t s;
    sgdrd_top_state_t next_s;

    logic [20:0] dec_size;
    logic        dec_last;
    logic [23:0] dec_offs;
    logic [7:0]  dec_err;
    logic        in_push;
    logic        in_ready;
    logic        in_empty;
    logic        out_push;
    logic        out_ready;
    logic        out_empty;
    logic        buf_ready;
    logic        buf_empty;
    logic [20:0] step;
    logic [55:0] in_head;
    logic [63:0] out_head;

    ////////////////////////////////////////////////////////////////////////////
    // descriptor fields and the two data buffers

    sgdrd_decoder u_dec (
        .ctl_in      (s.w_ctl),
        .offs_in     (s.w_offs),
        .outbound_in (s.chan),
        .size_out    (dec_size),
        .last_out    (dec_last),
        .offs_out    (dec_offs),
        .err_out     (dec_err)
    );

    // inbound: host read data plus its local address go to memory writes
    assign in_push  = (s.st == sgdrd_pkg::ST_MWAIT) && !s.chan && host_rdata_valid_in;
    // outbound: memory read data plus its host address go to host writes
    assign out_push = (s.st == sgdrd_pkg::ST_MWAIT) && s.chan && ddr_rdata_valid_in;

    sgdrd_buffer #(.WIDTH(56)) u_in_buf (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (in_push),
        .in_data_in    ({s.ddr, host_rdata_in}),
        .in_ready_out  (in_ready),
        .out_valid_out (ddr_wr_valid_out),
        .out_data_out  (in_head),
        .out_ready_in  (ddr_wr_ready_in),
        .empty_out     (in_empty)
    );

    sgdrd_buffer #(.WIDTH(64)) u_out_buf (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (out_push),
        .in_data_in    ({s.src, ddr_rdata_in}),
        .in_ready_out  (out_ready),
        .out_valid_out (host_wr_valid_out),
        .out_data_out  (out_head),
        .out_ready_in  (host_wr_ready_in),
        .empty_out     (out_empty)
    );

    assign ddr_wr_addr_out  = in_head[55:32];
    assign ddr_wr_data_out  = in_head[31:0];
    assign host_wr_addr_out = out_head[63:32];
    assign host_wr_data_out = out_head[31:0];
    assign buf_ready        = s.chan ? out_ready : in_ready;
    assign buf_empty        = s.chan ? out_empty : in_empty;
    // last word of a descriptor whose length is not a multiple of four counts only its real bytes
    assign step = (s.left >= sgdrd_pkg::WORD_STEP) ? sgdrd_pkg::WORD_STEP : s.left;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.done   = 2'b00;
        unique case (s.st)
            sgdrd_pkg::ST_IDLE: begin
                if (s.pend != 2'b00) begin
                    next_s.chan           = !s.pend[0];
                    next_s.pend[!s.pend[0]] = 1'b0;
                    next_s.desc_ptr       = s.ptr[!s.pend[0]];
                    next_s.clks[!s.pend[0]]  = sgdrd_pkg::RST_WORD;
                    next_s.err[!s.pend[0]]   = sgdrd_pkg::ERR_NONE;
                    next_s.bytes[!s.pend[0]] = '0;
                    next_s.fidx           = '0;
                    next_s.st             = sgdrd_pkg::ST_FREQ;
                end
            end
            sgdrd_pkg::ST_FREQ: begin
                next_s.hrd_v = 1'b1;
                next_s.hrd_a = s.desc_ptr + {28'h000_0000, s.fidx, 2'h0};
                if (s.hrd_v && host_rd_ready_in) begin
                    next_s.hrd_v = 1'b0;
                    next_s.st    = sgdrd_pkg::ST_FWAIT;
                end
            end
            sgdrd_pkg::ST_FWAIT: begin
                if (host_rdata_valid_in) begin
                    // second word of the descriptor is reserved and dropped
                    unique case (s.fidx)
                        2'h0: next_s.w_host = host_rdata_in;
                        2'h1: ;
                        2'h2: next_s.w_ctl  = host_rdata_in;
                        2'h3: next_s.w_offs = host_rdata_in;
                    endcase
                    next_s.fidx = s.fidx + 2'h1;
                    next_s.st   = (s.fidx == sgdrd_pkg::LAST_WORD_IDX) ?
                                  sgdrd_pkg::ST_DEC : sgdrd_pkg::ST_FREQ;
                end
            end
            sgdrd_pkg::ST_DEC: begin
                if (dec_err != sgdrd_pkg::ERR_NONE) begin
                    next_s.err[s.chan] = dec_err;
                    next_s.st          = sgdrd_pkg::ST_DONE;
                end else begin
                    next_s.src  = s.w_host;
                    next_s.ddr  = dec_offs;
                    next_s.left = dec_size;
                    next_s.st   = sgdrd_pkg::ST_MREQ;
                end
            end
            sgdrd_pkg::ST_MREQ: begin
                next_s.clks[s.chan] = s.clks[s.chan] + 32'h1;
                if (s.left == '0) begin
                    next_s.st = sgdrd_pkg::ST_DRAIN;
                end else if (!s.chan) begin
                    // one read in flight, issued only with room, so no word is lost
                    if (buf_ready || s.hrd_v) begin
                        next_s.hrd_v = 1'b1;
                        next_s.hrd_a = s.src;
                    end
                    if (s.hrd_v && host_rd_ready_in) begin
                        next_s.hrd_v = 1'b0;
                        next_s.st    = sgdrd_pkg::ST_MWAIT;
                    end
                end else begin
                    if (buf_ready || s.drd_v) begin
                        next_s.drd_v = 1'b1;
                        next_s.drd_a = s.ddr;
                    end
                    if (s.drd_v && ddr_rd_ready_in) begin
                        next_s.drd_v = 1'b0;
                        next_s.st    = sgdrd_pkg::ST_MWAIT;
                    end
                end
            end
            sgdrd_pkg::ST_MWAIT: begin
                next_s.clks[s.chan] = s.clks[s.chan] + 32'h1;
                if (in_push || out_push) begin
                    next_s.bytes[s.chan] = s.bytes[s.chan] + {3'h0, step};
                    next_s.left          = s.left - step;
                    next_s.src           = s.src + sgdrd_pkg::WORD_BYTES;
                    next_s.ddr           = s.ddr + sgdrd_pkg::WORD_BYTES[23:0];
                    next_s.st            = sgdrd_pkg::ST_MREQ;
                end
            end
            sgdrd_pkg::ST_DRAIN: begin
                next_s.clks[s.chan] = s.clks[s.chan] + 32'h1;
                if (buf_empty) begin
                    if (dec_last) begin
                        next_s.st = sgdrd_pkg::ST_DONE;
                    end else begin
                        next_s.desc_ptr = s.desc_ptr + sgdrd_pkg::DESC_BYTES;
                        next_s.fidx     = '0;
                        next_s.st       = sgdrd_pkg::ST_FREQ;
                    end
                end
            end
            sgdrd_pkg::ST_DONE: begin
                next_s.done[s.chan] = 1'b1;
                next_s.st           = sgdrd_pkg::ST_IDLE;
            end
        endcase

        // register writes come after the walk so a start set beats the take clear
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                sgdrd_pkg::OFF_SCRATCH: next_s.scratch = reg_wdata_in;
                sgdrd_pkg::OFF_CTRL: begin
                    next_s.ctrl = reg_wdata_in;
                    if (reg_wdata_in[15:0] == sgdrd_pkg::START_VAL) begin
                        next_s.pend[0] = 1'b1;
                    end
                    if (reg_wdata_in[31:16] == sgdrd_pkg::START_VAL) begin
                        next_s.pend[1] = 1'b1;
                    end
                end
                sgdrd_pkg::OFF_PTR_IN:  next_s.ptr[0]  = reg_wdata_in;
                sgdrd_pkg::OFF_PTR_OUT: next_s.ptr[1]  = reg_wdata_in;
                sgdrd_pkg::OFF_LAMP:    next_s.lamp    = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            next_s.rvalid = 1'b1;
            unique case (reg_addr_in)
                sgdrd_pkg::OFF_SCRATCH:    next_s.rdata = s.scratch;
                sgdrd_pkg::OFF_CTRL:       next_s.rdata = s.ctrl;
                sgdrd_pkg::OFF_PTR_IN:     next_s.rdata = s.ptr[0];
                sgdrd_pkg::OFF_STAT_IN_L:  next_s.rdata = {s.err[0], s.bytes[0]};
                sgdrd_pkg::OFF_STAT_IN_H:  next_s.rdata = s.clks[0];
                sgdrd_pkg::OFF_PTR_OUT:    next_s.rdata = s.ptr[1];
                sgdrd_pkg::OFF_STAT_OUT_L: next_s.rdata = {s.err[1], s.bytes[1]};
                sgdrd_pkg::OFF_STAT_OUT_H: next_s.rdata = s.clks[1];
                sgdrd_pkg::OFF_CLK_RATE:   next_s.rdata = sgdrd_pkg::CLK_HZ;
                sgdrd_pkg::OFF_DIP:        next_s.rdata = dip_in;
                sgdrd_pkg::OFF_LAMP:       next_s.rdata = s.lamp;
                default:                   next_s.rdata = sgdrd_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s    <= '0;
            s.st <= sgdrd_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_out     = s.rdata;
    assign reg_rvalid_out    = s.rvalid;
    assign host_rd_valid_out = s.hrd_v;
    assign host_rd_addr_out  = s.hrd_a;
    assign ddr_rd_valid_out  = s.drd_v;
    assign ddr_rd_addr_out   = s.drd_a;
    assign lamp_out          = s.lamp;
    assign chan_done_out     = s.done;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [31:0] stat_lo_in;
    logic [31:0] cur_clks;
    logic        dec_ok;
    assign stat_lo_in = {s.err[0], s.bytes[0]};
    assign cur_clks   = s.clks[s.chan];
    assign dec_ok     = (s.st == sgdrd_pkg::ST_DEC) && (dec_err == sgdrd_pkg::ERR_NONE);

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence fetch_last_s;
        (s.st == sgdrd_pkg::ST_FWAIT) && host_rdata_valid_in && (s.fidx == 2'h3);
    endsequence
    sequence finish_s;
        (s.st == sgdrd_pkg::ST_DONE) ##1 ((s.st == sgdrd_pkg::ST_IDLE) && (s.done != 2'b00));
    endsequence

    start_take_a: assert property (
        reg_wr_in && (reg_addr_in == sgdrd_pkg::OFF_CTRL) &&
        (reg_wdata_in[15:0] == sgdrd_pkg::START_VAL) |=> s.pend[0])
        else $error("inbound start not latched");
    stat_low_a: assert property (
        reg_rd_in && (reg_addr_in == sgdrd_pkg::OFF_STAT_IN_L) |=>
        reg_rvalid_out && (reg_rdata_out == $past(stat_lo_in)))
        else $error("inbound status low word wrong");
    clk_rate_a: assert property (
        reg_rd_in && (reg_addr_in == sgdrd_pkg::OFF_CLK_RATE) |=>
        reg_rdata_out == sgdrd_pkg::CLK_HZ)
        else $error("clock rate register wrong");
    fetch_four_a: assert property (fetch_last_s |=> s.st == sgdrd_pkg::ST_DEC)
        else $error("decode did not follow fourth word");
    desc_fields_a: assert property (
        dec_ok |=> (s.src == s.w_host) && (s.left == $past(dec_size)) &&
        (s.ddr == s.w_offs[23:0]))
        else $error("descriptor fields not loaded");
    bad_desc_a: assert property (
        (s.st == sgdrd_pkg::ST_DEC) && (dec_err != sgdrd_pkg::ERR_NONE) |=>
        (s.err[s.chan] != sgdrd_pkg::ERR_NONE) ##0 finish_s)
        else $error("bad descriptor did not stop channel");
    last_done_a: assert property (
        (s.st == sgdrd_pkg::ST_DRAIN) && buf_empty && dec_last |=> finish_s)
        else $error("last descriptor did not complete");
    timer_hold_a: assert property (
        (s.st == sgdrd_pkg::ST_FWAIT) || (s.st == sgdrd_pkg::ST_DEC) |=>
        cur_clks == $past(cur_clks))
        else $error("timer ran during descriptor handling");
    timer_run_a: assert property (
        s.st == sgdrd_pkg::ST_MREQ |=> cur_clks == $past(cur_clks) + 32'h1)
        else $error("timer idle during movement");
endmodule
`default_nettype wire

// ---- verilog/sgdrd_pkg.sv ----
// shared constants and types of the scatter-gather mover
`default_nettype none
package sgdrd_pkg;
    // register window offsets
    localparam logic [15:0] OFF_SCRATCH    = 16'hFC00;
    localparam logic [15:0] OFF_CTRL       = 16'hFC04;
    localparam logic [15:0] OFF_PTR_IN     = 16'hFC08;
    localparam logic [15:0] OFF_STAT_IN_L  = 16'hFC10;
    localparam logic [15:0] OFF_STAT_IN_H  = 16'hFC14;
    localparam logic [15:0] OFF_PTR_OUT    = 16'hFC18;
    localparam logic [15:0] OFF_STAT_OUT_L = 16'hFC20;
    localparam logic [15:0] OFF_STAT_OUT_H = 16'hFC24;
    localparam logic [15:0] OFF_CLK_RATE   = 16'hFC28;
    localparam logic [15:0] OFF_DIP        = 16'hFC30;
    localparam logic [15:0] OFF_LAMP       = 16'hFCA0;
    localparam logic [15:0] START_VAL      = 16'h0001;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    // descriptor field layout
    localparam int          SIZE_LSB       = 0;
    localparam int          SIZE_W         = 21;
    localparam int          DIR_LSB        = 21;
    localparam int          LAST_BIT       = 23;
    localparam int          MARK_LSB       = 24;
    localparam int          OFFS_W         = 24;
    localparam logic [7:0]  VALID_MARK     = 8'hAA;
    localparam logic [1:0]  DIR_READ       = 2'h1;
    localparam logic [1:0]  DIR_WRITE      = 2'h2;
    localparam logic [7:0]  ERR_NONE       = 8'h00;
    localparam logic [7:0]  ERR_MARK       = 8'h01;
    localparam logic [7:0]  ERR_DIR        = 8'h02;
    localparam logic [31:0] DESC_BYTES     = 32'h0000_0010;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
    localparam logic [20:0] WORD_STEP      = 21'h00_0004;
    localparam logic [1:0]  LAST_WORD_IDX  = 2'h3;
    localparam logic [23:0] DDR_BASE       = 24'h00_0000;
    // engine clock: 50 ns period
    localparam int          CLK_PERIOD_NS  = 32'h0000_0032;
    localparam logic [31:0] CLK_HZ         = 32'(64'h3B9A_CA00 / CLK_PERIOD_NS);
    typedef enum logic [2:0] {
        ST_IDLE, ST_FREQ, ST_FWAIT, ST_DEC, ST_MREQ, ST_MWAIT, ST_DRAIN, ST_DONE
    } sgdrd_state_t;
endpackage
`default_nettype wire

// ---- verilog/sgdrd_buffer.sv ----
// two-entry buffer with valid/ready on both sides; head entry drives the output
`default_nettype none
module sgdrd_buffer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in,
    output logic                  empty_out
);
    typedef struct packed {
        logic [WIDTH-1:0] d1;
        logic [WIDTH-1:0] d0;
        logic             v1;
        logic             v0;
    } sgdrd_buf_state_t;

    sgdrd_buf_state_t s;
    sgdrd_buf_state_t next_s;

    always_comb begin
        next_s = s;
        // pop first so a freed head is refilled from the skid entry
        if (s.v0 && out_ready_in) begin
            next_s.v0 = s.v1;
            next_s.d0 = s.d1;
            next_s.v1 = 1'b0;
        end
        if (in_valid_in && !s.v1) begin
            if (!next_s.v0) begin
                next_s.v0 = 1'b1;
                next_s.d0 = in_data_in;
            end else begin
                next_s.v1 = 1'b1;
                next_s.d1 = in_data_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_out  = !s.v1;
    assign out_valid_out = s.v0;
    assign out_data_out  = s.d0;
    assign empty_out     = !s.v0;
endmodule
`default_nettype wire

// ---- verilog/sgdrd_decoder.sv ----
// splits the control and offset words of a descriptor into fields and checks them
`default_nettype none
module sgdrd_decoder (
    input  wire logic [31:0] ctl_in,
    input  wire logic [31:0] offs_in,
    input  wire logic        outbound_in,
    output logic      [20:0] size_out,
    output logic             last_out,
    output logic      [23:0] offs_out,
    output logic      [7:0]  err_out
);
    logic [1:0] dir;
    logic [1:0] want;

    assign size_out = ctl_in[sgdrd_pkg::SIZE_LSB +: sgdrd_pkg::SIZE_W];
    assign dir      = ctl_in[sgdrd_pkg::DIR_LSB +: 2];
    assign last_out = ctl_in[sgdrd_pkg::LAST_BIT];
    assign offs_out = sgdrd_pkg::DDR_BASE + offs_in[sgdrd_pkg::OFFS_W-1:0];
    // the inbound channel reads host memory, the outbound one writes it
    assign want     = outbound_in ? sgdrd_pkg::DIR_WRITE : sgdrd_pkg::DIR_READ;

    always_comb begin
        if (ctl_in[sgdrd_pkg::MARK_LSB +: 8] != sgdrd_pkg::VALID_MARK) begin
            err_out = sgdrd_pkg::ERR_MARK;
        end else if (dir != want) begin
            err_out = sgdrd_pkg::ERR_DIR;
        end else begin
            err_out = sgdrd_pkg::ERR_NONE;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/_unused_placeholder_never.sv ----
// empty compilation unit kept out of the build; holds no logic
`default_nettype none
`default_nettype wire

// ---- tb/sgdrd_partner.sv ----
// partner model: host memory behind the endpoint and the local memory
`default_nettype none
module sgdrd_partner (
    input  wire logic        clk_sys_in,
    input  wire logic        hrd_valid_in,
    input  wire logic [31:0] hrd_addr_in,
    output logic             hrdata_valid_out,
    output logic      [31:0] hrdata_out,
    input  wire logic        drd_valid_in,
    input  wire logic [23:0] drd_addr_in,
    output logic             drdata_valid_out,
    output logic      [31:0] drdata_out,
    output logic             dwr_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] hmem [64];
    initial {hrdata_valid_out, drdata_valid_out, dwr_ready_out, hrdata_out, drdata_out} = '0;
    // local writes stall every other cycle so the buffer backs up
    always @(posedge clk_sys_in) begin
        dwr_ready_out <= ~dwr_ready_out;
        hrdata_valid_out <= hrd_valid_in;
        hrdata_out <= hrd_valid_in ? hmem[hrd_addr_in[7:2]] : ~hrdata_out;
        drdata_valid_out <= drd_valid_in;
        drdata_out <= drd_valid_in ? {8'hD0, drd_addr_in} : ~drdata_out;
    end
endmodule
`default_nettype wire

// ---- tb/sg_dma_register_and_descriptor_tb.sv ----
// bench: register window, inbound walk and outbound error codes
`default_nettype none
module sg_dma_register_and_descriptor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0, dip = 32'h0000_005A, rdata, hra, hrd, hwa, hwd, lamp, drd, dwd, v;
    logic [31:0] hw_last, dw_last, ctl [3] = '{32'h55C0_0008, 32'hAAA0_0008, 32'hAAC0_0008};
    logic [31:0] sts [3] = '{32'h0100_0000, 32'h0200_0000, 32'h0000_0008};
    logic [31:0] hwa_last;
    logic        rvalid, hrv, hrdv, hwv, drv, drdv, dwv, dwr;
    logic [23:0] dra, dwa, dwa_last;
    logic [1:0]  done;
    int          err_count = 0, check_count = 0, cyc = 0;
    sgdrd_top dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .host_rd_valid_out(hrv), .host_rd_addr_out(hra), .host_rd_ready_in(1'b1),
        .host_rdata_valid_in(hrdv), .host_rdata_in(hrd), .host_wr_valid_out(hwv),
        .host_wr_addr_out(hwa), .host_wr_data_out(hwd), .host_wr_ready_in(1'b1),
        .ddr_rd_valid_out(drv), .ddr_rd_addr_out(dra), .ddr_rd_ready_in(1'b1),
        .ddr_rdata_valid_in(drdv), .ddr_rdata_in(drd), .ddr_wr_valid_out(dwv),
        .ddr_wr_addr_out(dwa), .ddr_wr_data_out(dwd), .ddr_wr_ready_in(dwr), .dip_in(dip),
        .lamp_out(lamp), .chan_done_out(done));
    sgdrd_partner partner (.clk_sys_in(clk_sys_in), .hrd_valid_in(hrv), .hrd_addr_in(hra),
        .hrdata_valid_out(hrdv), .hrdata_out(hrd), .drd_valid_in(drv), .drd_addr_in(dra),
        .drdata_valid_out(drdv), .drdata_out(drd), .dwr_ready_out(dwr));
    always #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        if (hwv) {hwa_last, hw_last} <= {hwa, hwd};
        if (dwv && dwr) {dwa_last, dw_last} <= {dwa, dwd};
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys_in) #1 {wr, addr, wdata} = {1'b1, a, d};
        @(posedge clk_sys_in) #1 wr = 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys_in) #1 {rd, addr} = {1'b1, a};
        @(posedge clk_sys_in) #1 rd = 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        rreg(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask
    task automatic wdone(input int ch);
        int n = 0;
        while (done[ch] !== 1'b1 && n < 600) begin
            @(posedge clk_sys_in) #1;
            n++;
        end
        chk("done", {31'h0, done[ch]}, 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        foreach (partner.hmem[i]) partner.hmem[i] = 32'hC0DE_0000 + 32'(i);
        // inbound descriptor at 0x0: ten bytes, a partial last word
        {partner.hmem[0], partner.hmem[2], partner.hmem[3]} = {32'hC0, 32'hAAA0_000A, 32'h100};
        repeat (10) @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        // a write to the read-only rate register must leave it untouched
        wreg(16'hFC28, 32'hFFFF_FFFF);
        rchk(16'hFC28, 32'h0131_2D00);
        wreg(16'hFC00, 32'hA5C3_0F96);
        rchk(16'hFC00, 32'hA5C3_0F96);
        rchk(16'hFC30, 32'h0000_005A);
        rchk(16'hFC3C, 32'h0000_0000);
        wreg(16'hFCA0, 32'h0000_00C3);
        chk("lamp", lamp, 32'h0000_00C3);
        wreg(16'hFC08, 32'h0000_0000);
        wreg(16'hFC04, 32'h0000_0001);
        wdone(0);
        rchk(16'hFC10, 32'h0000_000A);
        rreg(16'hFC14, v);
        chk("cycles", {31'h0, v != 32'h0}, 32'h1);
        chk("ddr addr", {8'h0, dwa_last}, 32'h0000_0108);
        chk("ddr data", dw_last, 32'hC0DE_0032);
        for (int i = 0; i < 3; i++) begin
            {partner.hmem[4*i+8], partner.hmem[4*i+10]} = {32'h80, ctl[i]};
            partner.hmem[4*i+11] = 32'h200;
            wreg(16'hFC18, 32'h20 + 32'(16 * i));
            wreg(16'hFC04, 32'h0001_0000);
            wdone(1);
            rchk(16'hFC20, sts[i]);
            // refused descriptors move nothing, so no cycles; two words take eight
            rchk(16'hFC24, (i == 2) ? 32'h0000_0008 : 32'h0000_0000);
        end
        chk("host data", hw_last, 32'hD000_0204);
        chk("host addr", hwa_last, 32'h0000_0084);
        rchk(16'hFC18, 32'h0000_0040);
        rchk(16'hFC04, 32'h0001_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
